// ===== logic/imf_pkg.sv
// imf_pkg: shared constants, field layout and carrier types of the
// interrupt mask / fifo level / receive configuration register bank.
// assumes one 40 MHz clock domain; all users import imf_pkg::*.
package imf_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h58;
  localparam logic [7:0] OFS_ENABLE = 8'h5c;
  localparam logic [7:0] OFS_PROBE  = 8'h64;
  localparam logic [7:0] OFS_LEVELS = 8'h68;
  localparam logic [7:0] OFS_RXCFG  = 8'h6c;

  // fixed byte-order probe pattern
  localparam logic [31:0] PROBE_VALUE = 32'h8765_4321;

  // interrupt source bit positions, shared by status and enable
  localparam int BIT_SW        = 31;
  localparam int BIT_TX_HALT   = 25;
  localparam int BIT_RX_HALT   = 24;
  localparam int BIT_DROP_HALF = 23;
  localparam int BIT_TX_DONE   = 21;
  localparam int BIT_RX_DMA    = 20;
  localparam int BIT_TIMER     = 19;
  localparam int BIT_XCVR      = 18;
  localparam int BIT_POWER     = 17;
  localparam int BIT_TX_STS_OV = 16;
  localparam int BIT_RX_WDOG   = 15;
  localparam int BIT_RX_ERR    = 14;
  localparam int BIT_TX_ERR    = 13;
  localparam int BIT_TX_OVRUN  = 10;
  localparam int BIT_TX_SPACE  = 9;
  localparam int BIT_TX_STS_FL = 8;
  localparam int BIT_TX_STS_LV = 7;
  localparam int BIT_DROPPED   = 6;
  localparam int BIT_RX_STS_FL = 4;
  localparam int BIT_RX_STS_LV = 3;
  localparam int BIT_PIN0      = 0;

  // implemented interrupt bits; the rest are reserved and read zero
  localparam logic [31:0] IRQ_MASK =
    (32'h1 << BIT_SW) | (32'h1 << BIT_TX_HALT) | (32'h1 << BIT_RX_HALT) |
    (32'h1 << BIT_DROP_HALF) | (32'h1 << BIT_TX_DONE) | (32'h1 << BIT_RX_DMA) |
    (32'h1 << BIT_TIMER) | (32'h1 << BIT_XCVR) | (32'h1 << BIT_POWER) |
    (32'h1 << BIT_TX_STS_OV) | (32'h1 << BIT_RX_WDOG) | (32'h1 << BIT_RX_ERR) |
    (32'h1 << BIT_TX_ERR) | (32'h1 << BIT_TX_OVRUN) | (32'h1 << BIT_TX_SPACE) |
    (32'h1 << BIT_TX_STS_FL) | (32'h1 << BIT_TX_STS_LV) | (32'h1 << BIT_DROPPED) |
    (32'h1 << BIT_RX_STS_FL) | (32'h1 << BIT_RX_STS_LV) | (32'h7 << BIT_PIN0);

  // level threshold fields
  localparam int LVL_W         = 8;
  localparam int TX_SPACE_LSB  = 24;
  localparam int TX_STS_LSB    = 16;
  localparam int RX_STS_LSB    = 0;
  localparam logic [7:0] TX_SPACE_RST = 8'h48;
  localparam logic [7:0] TX_STS_RST   = 8'h00;
  localparam logic [7:0] RX_STS_RST   = 8'h00;

  // receive configuration fields
  localparam int CNT_W        = 12;
  localparam int ALIGN_LSB    = 30;
  localparam int DMA_CNT_LSB  = 16;
  localparam int DISCARD_BIT  = 15;
  localparam int OFS_BYTE_LSB = 8;
  localparam int OFS_DW_LSB   = 10;
  localparam logic [11:0] DMA_CNT_RST = 12'h000;

  // end alignment selection
  typedef enum logic [1:0] {
    ALIGN4  = 2'b00,
    ALIGN16 = 2'b01,
    ALIGN32 = 2'b10,
    ALIGNRS = 2'b11
  } imf_align_type;

  // fifo free space and occupancy levels from the queue logic
  typedef struct packed {
    logic [7:0] txFreeBlocks;
    logic [7:0] txStsUsed;
    logic [7:0] rxStsUsed;
  } imf_levels_type;

  // receive path controls towards the data queue
  typedef struct packed {
    logic          discard;
    imf_align_type align;
    logic [1:0]    offsetBytes;
    logic [2:0]    offsetDwords;
    logic [2:0]    padDwords;
  } imf_rxctl_type;

  // whole state of the register bank
  typedef struct packed {
    logic [31:0]   intEnable;
    logic [31:0]   intStatus;
    logic [7:0]    txSpaceLvl;
    logic [7:0]    txStsLvl;
    logic [7:0]    rxStsLvl;
    imf_align_type align;
    logic [11:0]   dmaCount;
    logic [1:0]    offLow;
    logic [2:0]    offHigh;
    logic [2:0]    offHighAct;
    logic          discard;
    logic [31:0]   rdData;
    logic          irq;
  } imf_state_type;

  localparam imf_state_type STATE_RST = '{
    intEnable:  32'h0000_0000,
    intStatus:  32'h0000_0000,
    txSpaceLvl: TX_SPACE_RST,
    txStsLvl:   TX_STS_RST,
    rxStsLvl:   RX_STS_RST,
    align:      ALIGN4,
    dmaCount:   DMA_CNT_RST,
    offLow:     2'h0,
    offHigh:    3'h0,
    offHighAct: 3'h0,
    discard:    1'b0,
    rdData:     32'h0000_0000,
    irq:        1'b0
  };

endpackage : imf_pkg

// ===== logic/imf_level_cmp.sv
// imf_level_cmp: registered "level above threshold" compare.
// assumes level and threshold come from logic on sys_clk.
module imf_level_cmp
  import imf_pkg::*;
#(
  parameter int W = LVL_W
)
(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] threshold,
  output logic              above
);

  logic above_r;
  logic above_nxt;

  // strictly greater than the programmed level
  always_comb
  begin
    above_nxt = (level > threshold);
  end

  // compare result register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      above_r <= 1'b0;
    else
      above_r <= above_nxt;
  end

  assign above = above_r;

endmodule : imf_level_cmp

// ===== logic/imf_pad_calc.sv
// imf_pad_calc: pad dwords needed to reach the selected end alignment.
// assumes bufDwords is the dword length of the buffer being read out.
module imf_pad_calc
  import imf_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  imf_align_type      align,
  input  wire logic [CW-1:0] bufDwords,
  output logic [2:0]         padDwords
);

  logic [2:0] pad_r;
  logic [2:0] pad_nxt;

  // pad = (unit - len mod unit) mod unit, unit in dwords
  always_comb
  begin
    unique case (align)
      ALIGN16: pad_nxt = {1'b0, 2'(3'h4 - {1'b0, bufDwords[1:0]})};
      ALIGN32: pad_nxt = 3'(4'h8 - {1'b0, bufDwords[2:0]});
      default: pad_nxt = 3'h0; // 4-byte and reserved need no pad
    endcase
  end

  // pad count register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pad_r <= 3'h0;
    else
      pad_r <= pad_nxt;
  end

  assign padDwords = pad_r;

endmodule : imf_pad_calc

// ===== logic/imf_reg_bank.sv
// imf_reg_bank: interrupt enable mask, status flags, byte-order probe,
// fifo level thresholds and receive configuration of the controller.
// assumes a plain register port on sys_clk, event pulses and fifo levels
// from logic on the same clock, and one dword pop per rxDataPop pulse.
module imf_reg_bank
  import imf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic [31:0] srcEvents,
  input  imf_levels_type   levels,
  input  wire logic        rxDataPop,
  input  wire logic [11:0] rxBufDwords,
  output imf_rxctl_type    rxCtl,
  output logic             irq
);

  imf_state_type st_r;
  imf_state_type st_nxt;

  logic        txSpaceAbove;
  logic        txStsAbove;
  logic        rxStsAbove;
  logic [2:0]  padDwords;
  logic [31:0] events;
  logic [31:0] clearMask;
  logic        dmaDone;
  logic        wrEnable;
  logic        wrStatus;
  logic        wrLevels;
  logic        wrRxCfg;

  // threshold compares for the three fifo level interrupts
  imf_level_cmp #(
    .W (LVL_W)
  ) u_txSpace (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .level     (levels.txFreeBlocks),
    .threshold (st_r.txSpaceLvl),
    .above     (txSpaceAbove)
  );

  imf_level_cmp #(
    .W (LVL_W)
  ) u_txSts (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .level     (levels.txStsUsed),
    .threshold (st_r.txStsLvl),
    .above     (txStsAbove)
  );

  imf_level_cmp #(
    .W (LVL_W)
  ) u_rxSts (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .level     (levels.rxStsUsed),
    .threshold (st_r.rxStsLvl),
    .above     (rxStsAbove)
  );

  // pad dwords for the end of the current receive buffer
  imf_pad_calc #(
    .CW (CNT_W)
  ) u_pad (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .align     (st_r.align),
    .bufDwords (rxBufDwords),
    .padDwords (padDwords)
  );

  // write decode
  always_comb
  begin
    wrEnable = regWr && (regAddr == OFS_ENABLE);
    wrStatus = regWr && (regAddr == OFS_STATUS);
    wrLevels = regWr && (regAddr == OFS_LEVELS);
    wrRxCfg  = regWr && (regAddr == OFS_RXCFG);
  end

  // dma count runs out on the pop that takes it from one to zero
  always_comb
  begin
    dmaDone = rxDataPop && (st_r.dmaCount == 12'h001) && !wrRxCfg;
  end

  // gather event sources; fifo level sources come from the compares
  always_comb
  begin
    events = srcEvents & IRQ_MASK;
    events[BIT_TX_SPACE]  = txSpaceAbove;
    events[BIT_TX_STS_LV] = txStsAbove;
    events[BIT_RX_STS_LV] = rxStsAbove;
    events[BIT_RX_DMA]    = dmaDone;
  end

  // write-one-to-clear mask for the status flags
  always_comb
  begin
    clearMask = wrStatus ? (regWdata & IRQ_MASK) : 32'h0000_0000;
  end

  // next state of the whole bank
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.discard = 1'b0;
    st_nxt.rdData = 32'h0000_0000;

    // status keeps recording regardless of the mask; set beats clear
    st_nxt.intStatus = (st_r.intStatus & ~clearMask) | events;

    // enable mask, reserved bits forced to zero
    if (wrEnable)
    begin
      st_nxt.intEnable = regWdata & IRQ_MASK;
    end

    // fifo level thresholds
    if (wrLevels)
    begin
      st_nxt.txSpaceLvl = regWdata[TX_SPACE_LSB +: LVL_W];
      st_nxt.txStsLvl   = regWdata[TX_STS_LSB +: LVL_W];
      st_nxt.rxStsLvl   = regWdata[RX_STS_LSB +: LVL_W];
    end

    // dma count: pop decrements, a write replaces what remains
    if (wrRxCfg)
    begin
      st_nxt.dmaCount = regWdata[DMA_CNT_LSB +: CNT_W];
    end
    else if (rxDataPop && (st_r.dmaCount != 12'h000))
    begin
      st_nxt.dmaCount = st_r.dmaCount - 12'h001;
    end

    // receive configuration fields
    if (wrRxCfg)
    begin
      st_nxt.align   = imf_align_type'(regWdata[ALIGN_LSB +: 2]);
      st_nxt.discard = regWdata[DISCARD_BIT];
      st_nxt.offLow  = regWdata[OFS_BYTE_LSB +: 2];
      st_nxt.offHigh = regWdata[OFS_DW_LSB +: 3];
    end

    // dword part of the offset takes effect at the next dword read
    if (rxDataPop)
    begin
      st_nxt.offHighAct = st_r.offHigh;
    end

    // discard empties queues, so a pending offset is applied at once
    if (st_r.discard)
    begin
      st_nxt.offHighAct = st_r.offHigh;
    end

    // read data, answered one cycle after the read strobe
    if (regRd)
    begin
      unique case (regAddr)
        OFS_ENABLE: st_nxt.rdData = st_r.intEnable;
        OFS_STATUS: st_nxt.rdData = st_r.intStatus;
        OFS_PROBE:  st_nxt.rdData = PROBE_VALUE;
        OFS_LEVELS:
        begin
          st_nxt.rdData[TX_SPACE_LSB +: LVL_W] = st_r.txSpaceLvl;
          st_nxt.rdData[TX_STS_LSB +: LVL_W]   = st_r.txStsLvl;
          st_nxt.rdData[RX_STS_LSB +: LVL_W]   = st_r.rxStsLvl;
        end
        OFS_RXCFG:
        begin
          st_nxt.rdData[ALIGN_LSB +: 2]       = st_r.align;
          st_nxt.rdData[DMA_CNT_LSB +: CNT_W] = st_r.dmaCount;
          st_nxt.rdData[OFS_BYTE_LSB +: 2]    = st_r.offLow;
          st_nxt.rdData[OFS_DW_LSB +: 3]      = st_r.offHigh;
        end
        default: st_nxt.rdData = 32'h0000_0000; // unmapped reads zero
      endcase
    end

    // request output from any enabled pending status
    st_nxt.irq = |(st_nxt.intStatus & st_nxt.intEnable);
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= STATE_RST;
    else
      st_r <= st_nxt;
  end

  // outputs, all from flip-flops
  assign regRdata = st_r.rdData;
  assign irq      = st_r.irq;

  // receive path controls; the host strips the pad
  assign rxCtl.discard      = st_r.discard;
  assign rxCtl.align        = st_r.align;
  assign rxCtl.offsetBytes  = st_r.offLow;
  assign rxCtl.offsetDwords = st_r.offHighAct;
  assign rxCtl.padDwords    = padDwords;

endmodule : imf_reg_bank

// ===== verification/imf_host_model.sv
// imf_host_model: host cpu on the plain register port, one access at a time.
// assumes sys_clk is the bank clock and that callers start after reset release.
module imf_host_model
(
  input  wire logic        sys_clk,
  output logic [7:0]       regAddr,
  output logic [31:0]      regWdata,
  output logic             regWr,
  output logic             regRd,
  input  wire logic [31:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one-cycle write; align and low offset bits change only between packets
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr    <= 1'b0;
    regWdata <= ~d; // released data no longer shows the last value
  endtask : wr

  // one-cycle read; data taken in the next cycle only, pad words never kept
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
endmodule : imf_host_model

// ===== verification/imf_reg_bank_props.sv
// imf_reg_bank_props: concurrent checks on the register bank ports.
// assumes one sys_clk domain with rstn active low; bound to imf_reg_bank.
module imf_reg_bank_props
  import imf_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic        rxDataPop,
  input imf_rxctl_type    rxCtl,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // write to the receive configuration
  wire rxWr = regWr && regAddr == OFS_RXCFG;

  chk_probe_value: assert property (
    $past(regRd) && $past(regAddr) == OFS_PROBE |-> regRdata == PROBE_VALUE)
    else $error("probe read wrong");
  chk_enable_clear: assert property (
    regWr && regAddr == OFS_ENABLE && regWdata == 32'h0 |=> !irq)
    else $error("irq with all enables cleared");
  chk_irq_fall: assert property (
    $fell(irq) |-> $past(regWr && (regAddr == OFS_STATUS || regAddr == OFS_ENABLE)))
    else $error("irq dropped without a write");
  chk_discard_pulse: assert property (
    rxWr && regWdata[DISCARD_BIT] |=> rxCtl.discard ##1 !rxCtl.discard)
    else $error("discard pulse wrong");
  chk_discard_cause: assert property (
    rxCtl.discard |-> $past(rxWr && regWdata[DISCARD_BIT]))
    else $error("discard without write");
  chk_align_write: assert property (
    rxWr |=> rxCtl.align == $past(regWdata[31:30]))
    else $error("align not taken");
  chk_offset_low: assert property (
    rxWr |=> rxCtl.offsetBytes == $past(regWdata[9:8]))
    else $error("byte offset not taken");
  chk_offset_hold: assert property (
    !rxDataPop && !rxCtl.discard && !$past(rxCtl.discard) |=> $stable(rxCtl.offsetDwords))
    else $error("dword offset moved without a pop");

  // main scenarios reached
  cover property (rxCtl.discard);
  cover property ($rose(irq));
  cover property ($past(regRd) && $past(regAddr) == OFS_PROBE);
endmodule : imf_reg_bank_props

bind imf_reg_bank imf_reg_bank_props props (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .rxDataPop(rxDataPop), .rxCtl(rxCtl), .irq(irq));

// ===== verification/testbench.sv
// testbench: random and corner traffic into the register bank via the host model.
// assumes imf_pkg, the design, the host model and the checker are compiled first.
module testbench
  import imf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic           sys_clk = 1'b0;
  logic           rstn;
  logic [7:0]     regAddr;
  logic [31:0]    regWdata, regRdata, srcEvents, v, en;
  logic           regWr, regRd, rxDataPop, irq;
  logic [1:0]     al;
  logic [11:0]    rxBufDwords, n;
  imf_levels_type levels;
  imf_rxctl_type  rxCtl;
  int             errorCnt = 0;
  int             checkCount = 0;

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  imf_reg_bank dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcEvents(srcEvents),
    .levels(levels), .rxDataPop(rxDataPop), .rxBufDwords(rxBufDwords), .rxCtl(rxCtl),
    .irq(irq));
  imf_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  // expected pad dwords: distance to the next 4 or 8 dword boundary
  function automatic logic [2:0] padExp(input logic [1:0] a, input logic [11:0] len);
    logic [2:0] m;
    m = (a == 2'b01) ? 3'h3 : (a == 2'b10) ? 3'h7 : 3'h0;
    return (3'h0 - len[2:0]) & m;
  endfunction : padExp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host.rd(a, r);
    chk(r, exp);
  endtask : rdChk

  task automatic pulse(input logic [31:0] e);
    @(posedge sys_clk);
    srcEvents <= e;
    @(posedge sys_clk);
    srcEvents <= 32'h0;
  endtask : pulse

  task automatic pop(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      rxDataPop <= 1'b1;
    end
    @(posedge sys_clk);
    rxDataPop <= 1'b0;
  endtask : pop

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic summarize;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    summarize();
  end

  // main sequence
  initial
  begin
    srcEvents = 32'h0;
    levels = '0;
    rxDataPop = 1'b0;
    rxBufDwords = 12'h000;
    rstn = 1'b0;
    void'($urandom(32'h96da));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rdChk(OFS_ENABLE, 32'h0);
    rdChk(OFS_LEVELS, 32'h4800_0000);
    rdChk(OFS_RXCFG, 32'h0);
    host.wr(OFS_PROBE, 32'h1234_5678);
    rdChk(OFS_PROBE, PROBE_VALUE);
    rdChk(8'h00, 32'h0);
    host.wr(OFS_ENABLE, 32'hffff_ffff);
    rdChk(OFS_ENABLE, IRQ_MASK);
    // random events under random masks
    repeat (6)
    begin
      v = $urandom & IRQ_MASK & ~32'h0010_0288;
      en = $urandom & IRQ_MASK;
      host.wr(OFS_ENABLE, en);
      pulse(v);
      rdChk(OFS_STATUS, v);
      chk({31'h0, irq}, {31'h0, |(v & en)});
      host.wr(OFS_STATUS, v);
      idle(1);
      chk({31'h0, irq}, 32'h0);
    end
    host.wr(OFS_ENABLE, 32'h0);
    // levels equal to thresholds, then one above
    host.wr(OFS_LEVELS, 32'h1005_0003);
    levels <= 24'h10_05_03;
    idle(3);
    host.wr(OFS_STATUS, 32'hffff_ffff);
    idle(3);
    rdChk(OFS_STATUS, 32'h0);
    @(posedge sys_clk);
    levels <= 24'h11_06_04;
    idle(3);
    rdChk(OFS_STATUS, 32'h0000_0288);
    @(posedge sys_clk);
    levels <= '0;
    // dma count with a rewrite before it runs out
    host.wr(OFS_RXCFG, 32'h0003_0000);
    pop(1);
    host.wr(OFS_RXCFG, 32'h0003_0000);
    host.wr(OFS_STATUS, 32'hffff_ffff);
    pop(2);
    idle(2);
    rdChk(OFS_RXCFG, 32'h0001_0000);
    rdChk(OFS_STATUS, 32'h0);
    pop(1);
    idle(2);
    rdChk(OFS_STATUS, 32'h0010_0000);
    host.wr(OFS_STATUS, 32'h0010_0000);
    rdChk(OFS_STATUS, 32'h0);
    // alignment, padding and offsets, reserved code included
    for (int i = 0; i < 8; i++)
    begin
      al = (i < 4) ? 2'(i) : 2'($urandom);
      n = 12'($urandom);
      v = {al, 17'h0, 5'($urandom), 8'h0};
      host.wr(OFS_RXCFG, v);
      rxBufDwords <= n;
      idle(3);
      chk(32'(rxCtl.padDwords), 32'(padExp(al, n)));
      chk(32'(rxCtl.align), 32'(al));
      chk(32'(rxCtl.offsetBytes), 32'(v[9:8]));
      pop(1);
      idle(1);
      chk(32'(rxCtl.offsetDwords), 32'(v[12:10]));
      rdChk(OFS_RXCFG, v);
    end
    host.wr(OFS_RXCFG, 32'h0000_8000);
    #1;
    chk(32'(rxCtl.discard), 32'h1);
    rdChk(OFS_RXCFG, 32'h0);
    chk(32'(rxCtl.discard), 32'h0);
    chk(32'(rxCtl.offsetDwords), 32'h0);
    summarize();
  end
endmodule : testbench
